/* File: hdl/pfi_regs.svh */
// Register offsets, reset values, field limits and timing counts of the pulse-rate input
`ifndef PFI_REGS_SVH
`define PFI_REGS_SVH
// Register byte offsets
`define PFI_OFF_DI_STATE   12'h000
`define PFI_OFF_MEAS_HZ    12'h004
`define PFI_OFF_FILT       12'h008
`define PFI_OFF_EN         12'h00C
`define PFI_OFF_GAIN       12'h010
`define PFI_OFF_LOW        12'h014
`define PFI_OFF_OFFS       12'h018
`define PFI_OFF_HIGH       12'h01C
`define PFI_OFF_POL        12'h020
`define PFI_OFF_RESULT     12'h024
`define PFI_OFF_MAXSPD     12'h028
`define PFI_OFF_SPEED      12'h02C
`define PFI_OFF_FNSEL      12'h030
// Reset values
`define PFI_RST_FILT       16'h0000
`define PFI_RST_EN         1'b0
`define PFI_RST_GAIN       16'h03E8
`define PFI_RST_LOW        16'h0064
`define PFI_RST_OFFS       16'h0000
`define PFI_RST_HIGH       16'h03E8
`define PFI_RST_POL        2'h0
`define PFI_RST_MAXSPD     16'h03E8
`define PFI_RST_FNSEL      6'h00
// Field limits and scaling
`define PFI_HZ_MIN         16'h0001
`define PFI_HZ_MAX         16'h0BB8
`define PFI_FILT_MAX       16'h0640
`define PFI_GAIN_MAX       16'h270F
`define PFI_OFFS_MAX       16'h03E8
`define PFI_UNIT           16'h03E8
`define PFI_FRAC_BITS      10
`define PFI_FRAC_CLAMP     32'h00000FFF
`define PFI_POL_SRC_HI     2'h2
`define PFI_DI3_BIT        2
`define PFI_SRC_FIRST      4
// Timing: gate time in ms, clock in Hz, derived counts
`define PFI_CLK_HZ         20000000
`define PFI_GATE_MS        1000
`define PFI_GATE_CYCLES    (`PFI_GATE_MS * (`PFI_CLK_HZ / 1000))
`define PFI_GATE_CS        (`PFI_GATE_MS / 10)
`define PFI_DIV_STEPS      6'h20
`endif

/* File: hdl/pfi_pkg.sv */
// Types of the pulse-rate input block
package pfi_pkg;
	// Result pipeline states
	typedef enum logic [2:0] {S_IDLE, S_DIV1, S_DIV2, S_DIV3, S_DIV4} pfi_state_t;

	// Whole state of the edge meter
	typedef struct packed {
		logic [7:0]  s1;     // First synchroniser stage
		logic [7:0]  s2;     // Second synchroniser stage
		logic        prev;   // Last level of the pulse input
		logic [11:0] edges;  // Edges in the running gate
		logic [31:0] timer;  // Gate timer
		logic [11:0] hz;     // Last completed count
		logic        done;   // Gate end pulse
	} pfi_meter_t;

	// Whole state of the core
	typedef struct packed {
		logic               pready;
		logic               pslverr;
		logic [31:0]        prdata;
		logic [15:0]        filt;
		logic               en;
		logic [15:0]        gain;
		logic [15:0]        low;
		logic [15:0]        offs;
		logic [15:0]        high;
		logic [1:0]         pol;
		logic [15:0]        maxspd;
		logic [5:0]         fnsel;
		logic [5:0]         fn_eff;
		logic [7:0]         di_state;
		logic [11:0]        hz;
		pfi_state_t         st;
		logic               neg;
		logic [16:0]        rem;
		logic [31:0]        quo;
		logic [15:0]        den;
		logic [5:0]         cnt;
		logic signed [17:0] y;
		logic [15:0]        spd;
		logic               rev;
	} pfi_core_t;
endpackage

/* File: hdl/pfi_meter_if.sv */
// Link between the edge meter and the core
`timescale 1ns/1ps
interface pfi_meter_if;
	logic        enable;    // Measurement active
	logic [11:0] hz;        // Pulses counted in last gate
	logic        gate_done; // One-cycle pulse at gate end
	logic [7:0]  di_level;  // Synchronised pin levels
	modport meter (input enable, output hz, output gate_done, output di_level);
	modport core  (output enable, input hz, input gate_done, input di_level);
endinterface

/* File: hdl/pfi_edge_meter.sv */
// Input synchroniser and gated rising-edge counter
`timescale 1ns/1ps
`include "pfi_regs.svh"
module pfi_edge_meter
	import pfi_pkg::*;
	#(parameter int unsigned GATE_CYCLES = `PFI_GATE_CYCLES)
	(
	// Clock and reset
	input wire logic  pclk,
	input wire logic  presetn,
	// Pins and core link
	input wire logic [7:0] di_pin,
	pfi_meter_if.meter     m
	);

	pfi_meter_t q;  // Registered state
	pfi_meter_t n;  // Next state

	// Edge counting; only the second stage is looked at
	always_comb
	begin
		n = q;
		n.s1 = di_pin;
		n.s2 = q.s1;
		n.prev = q.s2[`PFI_DI3_BIT];
		n.done = 1'b0;
		if (!m.enable)
		begin
			// Idle: gate restarts cleanly on enable
			n.edges = 12'h000;
			n.timer = 32'h00000000;
			n.hz = 12'h000;
		end
		else if (q.timer == GATE_CYCLES - 1)
		begin
			// Gate end: the count is the rate in Hz
			n.hz = q.edges;
			n.edges = 12'h000;
			n.timer = 32'h00000000;
			n.done = 1'b1;
		end
		else
		begin
			n.timer = q.timer + 32'h00000001;
			// Saturate so a fast source reads as top of band
			if (q.s2[`PFI_DI3_BIT] && !q.prev && q.edges < 12'(`PFI_HZ_MAX))
				n.edges = q.edges + 12'h001;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= n;
	end

	assign m.hz = q.hz;
	assign m.gate_done = q.done;
	assign m.di_level = q.s2;
endmodule // pfi_edge_meter

/* File: hdl/pfi_top.sv */
// Pulse-rate input with scaling, filter and digital input status over APB
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "pfi_regs.svh"
// Notes on behaviour
// - Pulse rate becomes 10-bit proportional quantity
// - Third input counts pulses up to 3000 Hz
// - Read-only measured rate in whole hertz
// - Enable measures, bypasses function, zeroes bit 2
// - Disabled forces measured rate zero; resets disabled
// - Filter time constant 0.00 to 16.00 s
// - Result is ((f-low)/(high-low)*100%+offset)*gain
// - Band limits 1 to 3000 Hz, 100/1000 default
// - Offset +-100.0 %, gain 0.000 to 9.999
// - Negative result means reverse, magnitude scales speed
// - Status byte bit n is input n+1
// - Status bit set when input active
// - Sinking active at 0 V, sourcing at 24 V
module pfi_top
	import pfi_pkg::*;
	#(parameter int unsigned GATE_CYCLES = `PFI_GATE_CYCLES)
	(
	// Clock and reset
	input wire logic         pclk,
	input wire logic         presetn,
	// APB slave
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [11:0]  paddr,
	input wire logic [31:0]  pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Digital input pins, 1 = high voltage
	input wire logic [7:0]   di_pin,
	// Results toward the drive
	output logic [7:0]        di_active,
	output logic [5:0]        third_fn_eff,
	output logic signed [17:0] pulse_rate_result,
	output logic [15:0]       speed_ref,
	output logic              speed_reverse
	);

	pfi_core_t q;  // Registered state
	pfi_core_t n;  // Next state

	// Link to the edge meter
	pfi_meter_if u_mif ();

	// Comb temporaries
	logic               ge;      // Divider step subtracts
	logic [16:0]        trial;   // Divider partial remainder
	logic [31:0]        qnext;   // Quotient after last step
	logic signed [13:0] num;     // Rate minus band low
	logic signed [13:0] dnm;     // Band width
	logic [12:0]        anum;    // Magnitude of num
	logic [12:0]        adnm;    // Magnitude of dnm
	logic [11:0]        frac;    // Clamped 10-bit-scaled fraction
	logic [21:0]        pmag;    // Fraction times 100.0 %
	logic signed [16:0] pct;     // Signed percent, tenths
	logic signed [31:0] prod;    // Percent plus offset, times gain
	logic signed [18:0] xval;    // New unfiltered result
	logic signed [18:0] diff;    // Step toward new result
	logic signed [17:0] ynew;    // Filtered result
	logic [17:0]        ymag;    // Filtered magnitude
	logic [7:0]         act;     // Active levels
	logic               src;     // Input is sourcing type
	logic               wr_ok;   // Write commits this edge

	// Offsets that answer without error
	function automatic logic is_mapped(input logic [11:0] a);
		case (a)
			`PFI_OFF_DI_STATE, `PFI_OFF_MEAS_HZ, `PFI_OFF_FILT, `PFI_OFF_EN,
			`PFI_OFF_GAIN, `PFI_OFF_LOW, `PFI_OFF_OFFS, `PFI_OFF_HIGH,
			`PFI_OFF_POL, `PFI_OFF_RESULT, `PFI_OFF_MAXSPD, `PFI_OFF_SPEED,
			`PFI_OFF_FNSEL:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	// Band limit clipping; keeps the divisor inside 12 bits
	function automatic logic [15:0] clip_hz(input logic [15:0] v);
		if (v < `PFI_HZ_MIN)
			clip_hz = `PFI_HZ_MIN;
		else if (v > `PFI_HZ_MAX)
			clip_hz = `PFI_HZ_MAX;
		else
			clip_hz = v;
	endfunction

	// Edge meter instance
	pfi_edge_meter #(.GATE_CYCLES(GATE_CYCLES)) u_meter (
		.pclk    (pclk),
		.presetn (presetn),
		.di_pin  (di_pin),
		.m       (u_mif.meter)
	);

	assign u_mif.enable = q.en;

	// Next-state logic: bus, status and result pipeline
	always_comb
	begin
		n = q;
		ge = 1'b0;
		trial = 17'h00000;
		qnext = 32'h00000000;
		num = 14'sh0000;
		dnm = 14'sh0000;
		anum = 13'h0000;
		adnm = 13'h0000;
		frac = 12'h000;
		pmag = 22'h000000;
		pct = 17'sh00000;
		prod = 32'sh00000000;
		xval = 19'sh00000;
		diff = 19'sh00000;
		ynew = 18'sh00000;
		ymag = 18'h00000;
		act = 8'h00;
		src = 1'b0;
		wr_ok = 1'b0;

		// One wait state: pready rises the cycle after the access phase starts
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !q.pready)
		begin
			n.pready = 1'b1;
			n.pslverr = !is_mapped(paddr);
			case (paddr)
				`PFI_OFF_DI_STATE: n.prdata = {24'h000000, q.di_state};
				`PFI_OFF_MEAS_HZ:  n.prdata = {20'h00000, q.hz};
				`PFI_OFF_FILT:     n.prdata = {16'h0000, q.filt};
				`PFI_OFF_EN:       n.prdata = {31'h00000000, q.en};
				`PFI_OFF_GAIN:     n.prdata = {16'h0000, q.gain};
				`PFI_OFF_LOW:      n.prdata = {16'h0000, q.low};
				`PFI_OFF_OFFS:     n.prdata = {{16{q.offs[15]}}, q.offs};
				`PFI_OFF_HIGH:     n.prdata = {16'h0000, q.high};
				`PFI_OFF_POL:      n.prdata = {30'h00000000, q.pol};
				`PFI_OFF_RESULT:   n.prdata = {{14{q.y[17]}}, q.y};
				`PFI_OFF_MAXSPD:   n.prdata = {16'h0000, q.maxspd};
				`PFI_OFF_SPEED:    n.prdata = {15'h0000, q.rev, q.spd};
				`PFI_OFF_FNSEL:    n.prdata = {26'h0000000, q.fnsel};
				default:           n.prdata = 32'h00000000;
			endcase
		end

		// Writes land on the edge that samples pready high
		wr_ok = psel && penable && q.pready && pwrite;
		if (wr_ok)
		begin
			case (paddr)
				`PFI_OFF_FILT:
					n.filt = (pwdata[15:0] > `PFI_FILT_MAX) ? `PFI_FILT_MAX : pwdata[15:0];
				`PFI_OFF_EN:
					n.en = pwdata[0];
				`PFI_OFF_GAIN:
					n.gain = (pwdata[15:0] > `PFI_GAIN_MAX) ? `PFI_GAIN_MAX : pwdata[15:0];
				`PFI_OFF_LOW:
					n.low = clip_hz(pwdata[15:0]);
				`PFI_OFF_OFFS:
					if ($signed(pwdata[15:0]) > $signed(`PFI_OFFS_MAX))
						n.offs = `PFI_OFFS_MAX;
					else if ($signed(pwdata[15:0]) < -$signed(`PFI_OFFS_MAX))
						n.offs = 16'h0000 - `PFI_OFFS_MAX;
					else
						n.offs = pwdata[15:0];
				`PFI_OFF_HIGH:
					n.high = clip_hz(pwdata[15:0]);
				`PFI_OFF_POL:
					n.pol = pwdata[1:0];
				`PFI_OFF_MAXSPD:
					n.maxspd = pwdata[15:0];
				`PFI_OFF_FNSEL:
					n.fnsel = pwdata[5:0];
				default:
					n.fnsel = q.fnsel; // Read-only or unmapped: no effect
			endcase
		end

		// Bit 2 is forced low below while the pin counts pulses
		// Input activity by type; reserved settings act as all sinking
		for (int i = 0; i < 8; i++)
		begin
			src = (q.pol == `PFI_POL_SRC_HI) && (i >= `PFI_SRC_FIRST);
			act[i] = src ? u_mif.di_level[i] : !u_mif.di_level[i];
		end
		if (q.en)
			act[`PFI_DI3_BIT] = 1'b0;
		n.di_state = act;
		// Pulse input takes the third input away from its function
		n.fn_eff = q.en ? 6'h00 : q.fnsel;

		// A disabled input reads zero at once, not at the next gate
		// Measured rate follows each gate, zero while off
		if (!q.en)
			n.hz = 12'h000;
		else if (u_mif.gate_done)
			n.hz = u_mif.hz;

		// One quotient bit per cycle; 32 steps cover the widest operand
		// Shared restoring divider step
		trial = {q.rem[15:0], q.quo[31]};
		ge = trial >= {1'b0, q.den};
		qnext = q.quo;
		if (q.st != S_IDLE && q.cnt != 6'h00)
		begin
			n.rem = ge ? (trial - {1'b0, q.den}) : trial;
			n.quo = {q.quo[30:0], ge};
			n.cnt = q.cnt - 6'h01;
		end

		// Each state waits out one divider pass, then loads the next:
		// fraction, then percent times gain, then filter step, then speed.
		// One shared divider costs about 33 cycles a pass, far below a gate.
		case (q.st)
			S_IDLE:
			begin
				if (q.en && u_mif.gate_done)
				begin
					// Offset into band over band width, scaled by 2^10
					num = $signed({2'b00, u_mif.hz}) - $signed({1'b0, q.low[12:0]});
					dnm = $signed({1'b0, q.high[12:0]}) - $signed({1'b0, q.low[12:0]});
					anum = num[13] ? 13'(-num) : num[12:0];
					adnm = dnm[13] ? 13'(-dnm) : dnm[12:0];
					n.neg = num[13] ^ dnm[13];
					// Empty band still divides by zero: every quotient bit sets, so the fraction clamps to 4095
					n.quo = (adnm == 13'h0000) ? 32'h00000000 :
						{9'h000, anum, 10'h000};
					n.den = {3'h0, adnm};
					n.rem = 17'h00000;
					n.cnt = `PFI_DIV_STEPS;
					n.st = S_DIV1;
				end
			end
			S_DIV1:
			begin
				if (q.cnt == 6'h00)
				begin
					// 10-bit fraction; clamp keeps out-of-band rates bounded
					frac = (qnext > `PFI_FRAC_CLAMP) ? 12'(`PFI_FRAC_CLAMP) : qnext[11:0];
					pmag = 22'(frac) * 22'(`PFI_UNIT);
					pct = $signed({5'h00, pmag[21:`PFI_FRAC_BITS]});
					if (q.neg)
						pct = -pct;
					pct = pct + $signed({q.offs[15], q.offs});
					prod = 32'(pct) * $signed({16'h0000, q.gain});
					n.neg = prod[31];
					n.quo = prod[31] ? 32'(-prod) : prod;
					n.den = `PFI_UNIT;
					n.rem = 17'h00000;
					n.cnt = `PFI_DIV_STEPS;
					n.st = S_DIV2;
				end
			end
			S_DIV2:
			begin
				if (q.cnt == 6'h00)
				begin
					xval = $signed({1'b0, qnext[17:0]});
					if (q.neg)
						xval = -xval;
					// Low-pass step: (x - y) * Ts / (tau + Ts)
					diff = xval - 19'(q.y);
					n.neg = diff[18];
					n.quo = 32'(diff[18] ? 19'(-diff) : diff) * 32'(`PFI_GATE_CS);
					n.den = q.filt + 16'(`PFI_GATE_CS);
					n.rem = 17'h00000;
					n.cnt = `PFI_DIV_STEPS;
					n.st = S_DIV3;
				end
			end
			S_DIV3:
			begin
				if (q.cnt == 6'h00)
				begin
					// Zero constant gives the full step, i.e. no smoothing
					ynew = q.neg ? (q.y - 18'(qnext)) : (q.y + 18'(qnext));
					n.y = ynew;
					// Sign selects direction, magnitude scales speed
					n.rev = ynew[17];
					ymag = ynew[17] ? 18'(-ynew) : ynew;
					n.quo = 32'(ymag) * 32'(q.maxspd);
					n.den = `PFI_UNIT;
					n.rem = 17'h00000;
					n.cnt = `PFI_DIV_STEPS;
					n.st = S_DIV4;
				end
			end
			S_DIV4:
			begin
				if (q.cnt == 6'h00)
				begin
					n.spd = (qnext > 32'h0000FFFF) ? 16'hFFFF : qnext[15:0];
					n.st = S_IDLE;
				end
			end
			default:
				n.st = S_IDLE;
		endcase
	end

	// State register with documented reset values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Clear everything, then load the defaults of the settings
			q <= '0;
			q.filt <= `PFI_RST_FILT;
			q.en <= `PFI_RST_EN;
			q.gain <= `PFI_RST_GAIN;
			q.low <= `PFI_RST_LOW;
			q.offs <= `PFI_RST_OFFS;
			q.high <= `PFI_RST_HIGH;
			q.pol <= `PFI_RST_POL;
			q.maxspd <= `PFI_RST_MAXSPD;
			q.fnsel <= `PFI_RST_FNSEL;
			q.st <= S_IDLE;
		end
		else
		begin
			q <= n;
		end
	end

	// Outputs straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign di_active = q.di_state;
	assign third_fn_eff = q.fn_eff;
	assign pulse_rate_result = q.y;
	assign speed_ref = q.spd;
	assign speed_reverse = q.rev;
endmodule // pfi_top

/* File: tb/pfi_top_sva.sv */
// Port-level properties of the pulse-rate input block
`timescale 1ns/1ps
`include "pfi_regs.svh"
module pfi_top_sva
	import pfi_pkg::*;
	#(parameter int unsigned GATE_CYCLES = 2000)
	(
	// Clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// APB slave
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [11:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	// Pins and results
	input wire logic [7:0]         di_pin,
	input wire logic [7:0]         di_active,
	input wire logic [5:0]         third_fn_eff,
	input wire logic signed [17:0] pulse_rate_result,
	input wire logic [15:0]        speed_ref,
	input wire logic               speed_reverse
	);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       en_q; // Enable bit as last written
	logic [2:0] up_q; // Cycles since reset, saturating
	// Shadow the enable bit, since the checker cannot see the register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_q <= 1'b0;
			up_q <= 3'h0;
		end
		else
		begin
			if (psel && penable && pready && pwrite && paddr == `PFI_OFF_EN)
				en_q <= pwdata[0];
			if (up_q != 3'h7)
				up_q <= up_q + 3'h1;
		end
	end
	// Access phase waiting for its answer
	sequence s_access;
		psel && penable && !pready;
	endsequence
	// One-cycle answer
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	// New filtered result
	sequence s_new_result;
		$changed(pulse_rate_result);
	endsequence
	AST_ONE_WAIT: assert property (s_access |=> s_answer)
		else $error("pready not one cycle after access");
	AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_RDATA_HOLD: assert property (!pready |-> $stable(prdata))
		else $error("read data moved between reads");
	AST_EN_BIT2: assert property (en_q && $past(en_q, 3) |-> !di_active[2] && third_fn_eff == 6'h00)
		else $error("third input not bypassed while enabled");
	AST_SINK_LOW: assert property ((up_q == 3'h7 && $stable(di_pin[1:0])) [*4] |-> di_active[1:0] == ~di_pin[1:0])
		else $error("sinking input state wrong");
	AST_DIR_FOLLOWS: assert property (s_new_result |-> ##[1:60] speed_reverse == pulse_rate_result[17])
		else $error("direction does not follow result sign");
endmodule // pfi_top_sva
bind pfi_top pfi_top_sva #(.GATE_CYCLES(GATE_CYCLES)) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.di_pin(di_pin), .di_active(di_active), .third_fn_eff(third_fn_eff),
	.pulse_rate_result(pulse_rate_result), .speed_ref(speed_ref), .speed_reverse(speed_reverse)
);

/* File: tb/pfi_pulse_src.sv */
// Pulse source on the third input and switch contacts on the others
`timescale 1ns/1ps
module pfi_pulse_src
	(
	// Clock
	input wire logic  pclk,
	// Control from the bench
	input wire logic        run,
	input wire logic [7:0]  half,
	input wire logic [7:0]  lvl,
	// Pins
	output logic [7:0]      di_pin
	);
	logic [7:0] cnt_q; // Half-period counter
	logic       ph_q;  // Pulse level, low while stopped
	// Square wave of period 2*half cycles
	always_ff @(posedge pclk)
	begin
		if (!run || cnt_q >= half - 8'h01)
		begin
			cnt_q <= 8'h00;
			ph_q  <= run ? ~ph_q : 1'b0;
		end
		else
			cnt_q <= cnt_q + 8'h01;
	end
	assign di_pin = {lvl[7:3], ph_q, lvl[1:0]};
endmodule // pfi_pulse_src

/* File: tb/pulse_frequency_input_and_di_status_tb_top.sv */
// Self-checking bench of the pulse-rate input block
`timescale 1ns/1ps
`include "pfi_regs.svh"
module pulse_frequency_input_and_di_status_tb_top;
	import pfi_pkg::*;
	localparam int unsigned GATE = 2000; // Short gate keeps the run brief
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata;
	logic [7:0]        di_pin, di_active, half, lvl;
	logic [5:0]        third_fn_eff;
	logic signed [17:0] pulse_rate_result;
	logic [15:0]       speed_ref;
	logic              speed_reverse, run;
	logic [31:0]       seed_q = 32'hE9D931A9; // Fixed seed
	int                miscompares = 0;
	int                checks_done = 0;
	pfi_top #(.GATE_CYCLES(GATE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .di_pin(di_pin),
		.di_active(di_active), .third_fn_eff(third_fn_eff),
		.pulse_rate_result(pulse_rate_result), .speed_ref(speed_ref),
		.speed_reverse(speed_reverse));
	pfi_pulse_src u_src (.pclk(pclk), .run(run), .half(half), .lvl(lvl), .di_pin(di_pin));
	// 50 ns clock
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Next LFSR value
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected status byte; bit 2 pin is low while the source stands still
	function automatic logic [31:0] exp_di(input logic [7:0] l, input int p, input logic en);
		logic [7:0] v;
		v = ~{l[7:3], 1'b0, l[1:0]};
		if (p == 2)
			v[7:4] = l[7:4];
		if (en)
			v[2] = 1'b0;
		return {24'h0, v};
	endfunction
	// Expected result in 0.1 % units
	function automatic logic [31:0] exp_res(input int f, lo, hi, off, g);
		int fr;
		fr = (hi == lo) ? 0 : (f - lo) * 1024 / (hi - lo);
		fr = (fr > 4095) ? 4095 : fr;
		return 32'((fr * 1000 / 1024 + off) * g / 1000);
	endfunction
	// Expected speed word: magnitude times maximum speed over 1000, saturated
	function automatic logic [31:0] exp_spd(input logic [31:0] x, input longint m);
		longint v;
		v = longint'($signed(x));
		v = ((v < 0) ? -v : v) * m / 1000;
		return {15'h0, x[31], (v > 65535) ? 16'hFFFF : v[15:0]};
	endfunction
	// Expected filter output after two gate steps from a start value
	function automatic int exp_filt(input int y, input int x, input int tau);
		for (int k = 0; k < 2; k++)
			y = y + (x - y) * 100 / (tau + 100);
		return y;
	endfunction
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; only the watchdog bounds the wait for pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	localparam logic [43:0] RST [7] = '{{`PFI_OFF_FILT, 32'h0}, {`PFI_OFF_EN, 32'h0},
		{`PFI_OFF_GAIN, 32'h3E8}, {`PFI_OFF_LOW, 32'h64}, {`PFI_OFF_OFFS, 32'h0},
		{`PFI_OFF_HIGH, 32'h3E8}, {`PFI_OFF_MEAS_HZ, 32'h0}};
	// Main sequence
	initial
	begin
		logic [31:0] r, x;
		logic        e;
		int          off, g, ms, yv;
		{psel, penable, pwrite, paddr, pwdata, run, lvl} = '0;
		half    = 8'h04;
		yv      = 0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (RST[i])
		begin
			rd(RST[i][43:32], r);
			chk(r, RST[i][31:0]);
		end
		apb(1'b0, 12'h040, 32'h0, r, e);
		chk({r[31:1], e}, 32'h1);
		wr(`PFI_OFF_MEAS_HZ, 32'h123);
		rd(`PFI_OFF_MEAS_HZ, r);
		chk(r, 32'h0);
		$display("test registers done");
		for (int p = 0; p < 4; p++)
		begin
			wr(`PFI_OFF_POL, 32'(p));
			seed_q = lfsr(seed_q);
			lvl <= seed_q[7:0];
			repeat (5) @(posedge pclk);
			chk({24'h0, di_active}, exp_di(seed_q[7:0], p, 1'b0));
			rd(`PFI_OFF_DI_STATE, r);
			chk(r, exp_di(seed_q[7:0], p, 1'b0));
		end
		$display("test status done");
		wr(`PFI_OFF_FILT, 32'hFFFF);
		rd(`PFI_OFF_FILT, r);
		chk(r, 32'h640);
		wr(`PFI_OFF_GAIN, 32'hFFFF);
		rd(`PFI_OFF_GAIN, r);
		chk(r, 32'h270F);
		wr(`PFI_OFF_OFFS, 32'h8000);
		rd(`PFI_OFF_OFFS, r);
		chk(r, 32'hFFFFFC18);
		wr(`PFI_OFF_LOW, 32'h0);
		rd(`PFI_OFF_LOW, r);
		chk(r, 32'h1);
		wr(`PFI_OFF_HIGH, 32'hFFFF);
		rd(`PFI_OFF_HIGH, r);
		chk(r, 32'hBB8);
		$display("test limits done");
		wr(`PFI_OFF_FNSEL, 32'h15);
		wr(`PFI_OFF_LOW, 32'hC8);
		wr(`PFI_OFF_HIGH, 32'h190);
		for (int i = 0; i < 2; i++)
		begin
			seed_q = lfsr(seed_q);
			off = (i == 0) ? -1000 : int'(seed_q % 2001) - 1000;
			g = (i == 0) ? 9999 : int'(seed_q[15:0] % 10000);
			ms = (i == 0) ? 1000 : int'(seed_q[31:16]);
			wr(`PFI_OFF_OFFS, 32'(off));
			wr(`PFI_OFF_GAIN, 32'(g));
			wr(`PFI_OFF_FILT, 32'(i * 100));
			wr(`PFI_OFF_MAXSPD, 32'(ms));
			run <= 1'b1;
			wr(`PFI_OFF_EN, 32'h1);
			repeat (2 * GATE + 300) @(posedge pclk);
			chk({26'h0, third_fn_eff}, 32'h0);
			chk({24'h0, di_active}, exp_di(lvl, 0, 1'b1));
			rd(`PFI_OFF_MEAS_HZ, r);
			chk({31'h0, r >= 32'hF9 && r <= 32'hFB}, 32'h1);
			// Two gates have passed, so the filter has stepped twice
			yv = exp_filt(yv, $signed(exp_res(int'(r), 200, 400, off, g)), i * 100);
			x = 32'(yv);
			rd(`PFI_OFF_RESULT, r);
			chk(r, x);
			chk(32'(pulse_rate_result), x);
			rd(`PFI_OFF_SPEED, r);
			chk(r, exp_spd(x, ms));
			chk({16'h0, speed_ref}, exp_spd(x, ms) & 32'h0000FFFF);
			chk({31'h0, speed_reverse}, {31'h0, x[31]});
			wr(`PFI_OFF_EN, 32'h0);
			rd(`PFI_OFF_MEAS_HZ, r);
			chk(r, 32'h0);
			chk({26'h0, third_fn_eff}, 32'h15);
			run <= 1'b0;
		end
		$display("test measurement done");
		complete_run();
	end
	// Watchdog
	initial
	begin
		repeat (40000) @(posedge pclk);
		miscompares++;
		complete_run();
	end
endmodule // pulse_frequency_input_and_di_status_tb_top
